/* File: rtl/phrtc_top.sv */
// phantom clock: memory select gating, serial unlock, clock access, ahb
`timescale 1ns/10ps
module phrtc_top
    import phrtc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        chip_select_in_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_out_oe,
    output logic             gated_memory_select_n,
    input  wire logic        reset_pin_n,
    input  wire logic        power_fail_threshold,
    input  wire logic        crystal_in,
    output logic             crystal_out
);
    typedef struct packed {
        phrtc_mode_t  mode;
        logic [5:0]   ptr;
        logic [5:0]   idx;
        logic         in_cyc;
        logic         saw_we;
        logic         wbit;
        logic [7:0]   wbyte;
        logic [63:0]  shadow;
        logic         dout;
        logic [15:0]  acc;
        logic         xtal_d;
        logic         tick;
        logic         xo;
        logic         force_ds;
        logic         wr_pend;
        logic [3:0]   wr_addr;
        logic [31:0]  rdata;
        logic         load_en;
        logic [2:0]   load_idx;
        logic [7:0]   load_byte;
    } phrtc_state_t;

    phrtc_state_t state_r;
    phrtc_state_t state_nxt;
    logic [SYNC_W-1:0] pins_q;
    logic [63:0]       time_q;
    logic              cs_n_q;
    logic              oe_n_q;
    logic              we_n_q;
    logic              pwr_low_q;
    logic              blocked;
    logic              cyc_end;
    logic              addr_ph;

    phrtc_sync3 #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({crystal_in, power_fail_threshold, reset_pin_n,
                   data_in, write_enable_n, output_enable_n,
                   chip_select_in_n}),
        .q       (pins_q)
    );

    phrtc_calendar u_cal (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .tick      (state_r.tick),
        .load_en   (state_r.load_en),
        .load_idx  (state_r.load_idx),
        .load_byte (state_r.load_byte),
        .time_q    (time_q)
    );

    function automatic logic [31:0] reg_read(input logic [3:0] a,
                                             input phrtc_state_t s,
                                             input logic [63:0] t,
                                             input logic [6:0] p);
        unique case (a)
            REG_CTRL:    reg_read = {31'h0, s.force_ds};
            REG_STATUS:  reg_read = {10'h0, ~p[LN_RSTPIN], p[LN_PWRLOW],
                                     2'b00, s.mode, 2'b00, s.idx,
                                     2'b00, s.ptr};
            REG_TIME_LO: reg_read = t[31:0];
            REG_TIME_HI: reg_read = t[63:32];
            default:     reg_read = 32'h0000_0000;
        endcase
    endfunction

    assign cs_n_q    = pins_q[LN_CS];
    assign oe_n_q    = pins_q[LN_OE];
    assign we_n_q    = pins_q[LN_WE];
    assign pwr_low_q = pins_q[LN_PWRLOW];
    // reset pin aborts only while the day register lets it
    assign blocked   = pwr_low_q
                       | (~pins_q[LN_RSTPIN] & ~time_q[DAY_RST_BIT]);
    // a host cycle ends when chip select returns high
    assign cyc_end   = state_r.in_cyc & cs_n_q;
    assign addr_ph   = hsel & htrans[1] & hready;

    always_comb begin
        logic [16:0] sum;
        sum       = 17'h0_0000;
        state_nxt = state_r;
        state_nxt.tick    = 1'b0;
        state_nxt.load_en = 1'b0;

        // host cycle tracking: write wins if write enable went low
        if (!cs_n_q && !state_r.in_cyc) begin
            state_nxt.in_cyc = 1'b1;
            state_nxt.saw_we = 1'b0;
        end
        if (state_r.in_cyc && !cs_n_q && !we_n_q) begin
            state_nxt.saw_we = 1'b1;
            state_nxt.wbit   = pins_q[LN_DIN];
        end
        if (cyc_end) begin
            state_nxt.in_cyc = 1'b0;
        end

        if (blocked) begin
            // drop everything mid-stream; partial bytes never reach time
            state_nxt.mode = PHRTC_DEAD;
            state_nxt.ptr  = 6'h00;
            state_nxt.idx  = 6'h00;
        end else if (cyc_end) begin
            unique case (state_r.mode)
                PHRTC_DEAD: begin
                    if (!state_r.saw_we) begin
                        state_nxt.mode = PHRTC_ARMED;
                        state_nxt.ptr  = 6'h00;
                    end
                end
                PHRTC_ARMED: begin
                    if (!state_r.saw_we) begin
                        state_nxt.ptr = 6'h00;
                    end else if (state_r.wbit
                                 == UNLOCK_PATTERN[state_r.ptr]) begin
                        state_nxt.ptr = state_r.ptr + 6'h01;
                        if (state_r.ptr == LAST_BIT) begin
                            state_nxt.mode   = PHRTC_OPEN;
                            state_nxt.idx    = 6'h00;
                            state_nxt.shadow = time_q;
                        end
                    end else begin
                        state_nxt.mode = PHRTC_DEAD;
                    end
                end
                PHRTC_OPEN: begin
                    state_nxt.idx = state_r.idx + 6'h01;
                    if (state_r.saw_we) begin
                        state_nxt.wbyte[state_r.idx[2:0]] = state_r.wbit;
                        state_nxt.shadow[state_r.idx]     = state_r.wbit;
                        if (state_r.idx[2:0] == 3'h7) begin
                            state_nxt.load_en   = 1'b1;
                            state_nxt.load_idx  = state_r.idx[5:3];
                            state_nxt.load_byte = {state_r.wbit,
                                                   state_r.wbyte[6:0]};
                        end
                    end
                    if (state_r.idx == LAST_BIT) begin
                        state_nxt.mode = PHRTC_DEAD;
                        state_nxt.ptr  = 6'h00;
                    end
                end
                default: begin
                    state_nxt.mode = PHRTC_DEAD;
                end
            endcase
        end

        // read bit leads the cycle so it stands while output enable is low
        state_nxt.dout = state_nxt.shadow[state_nxt.idx];

        // hundredths from crystal edges: exact on average, jitter of one
        // edge per tick since 32768 is not a multiple of 100
        state_nxt.xtal_d = pins_q[LN_XTAL];
        state_nxt.xo     = ~pins_q[LN_XTAL] & ~time_q[DAY_OSC_BIT];
        if (pins_q[LN_XTAL] && !state_r.xtal_d) begin
            sum = {1'b0, state_r.acc} + {1'b0, TICK_HZ};
            if (sum >= {1'b0, XTAL_HZ}) begin
                sum            = sum - {1'b0, XTAL_HZ};
                state_nxt.tick = 1'b1;
            end
            state_nxt.acc = sum[15:0];
        end

        // ahb-lite slave, zero wait states
        state_nxt.wr_pend = addr_ph & hwrite;
        if (addr_ph) begin
            state_nxt.wr_addr = haddr[3:0];
            state_nxt.rdata   = hwrite ? 32'h0000_0000
                                : reg_read(haddr[3:0], state_r, time_q,
                                           pins_q);
        end
        if (state_r.wr_pend && state_r.wr_addr == REG_CTRL) begin
            state_nxt.force_ds = hwdata[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r          <= '0;
            state_r.mode     <= PHRTC_DEAD;
            state_r.force_ds <= CTRL_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // raw supply pin gates too, so memory is protected without sync lag
    assign gated_memory_select_n = chip_select_in_n
                                   | (state_r.mode == PHRTC_OPEN)
                                   | power_fail_threshold
                                   | pwr_low_q
                                   | state_r.force_ds;
    assign data_out    = state_r.dout;
    assign data_out_oe = (state_r.mode == PHRTC_OPEN) & ~blocked
                         & ~cs_n_q & ~oe_n_q & we_n_q;
    assign crystal_out = state_r.xo;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = state_r.rdata;
endmodule

/* File: rtl/phrtc_pkg.sv */
// constants and types shared by the phantom clock design
package phrtc_pkg;
    // unlock pattern, bit 0 goes first: bytes c5 3a a3 5c twice, lsb first
    localparam logic [63:0] UNLOCK_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;
    localparam logic [5:0]  LAST_BIT       = 6'h3f;

    // calendar state after reset: date, month and weekday 01, rest 00
    localparam logic [63:0] TIME_RST       = 64'h0001_0101_0000_0000;
    // bits that can be set in each timekeeping byte; the rest always read zero
    localparam logic [63:0] TIME_MASK      = 64'hff1f_3f37_bf7f_7fff;
    localparam int          DAY_RST_BIT    = 36;
    localparam int          DAY_OSC_BIT    = 37;

    // time base: crystal edges per second and hundredth ticks per second
    localparam logic [15:0] XTAL_HZ        = 16'h8000;
    localparam logic [15:0] TICK_HZ        = 16'h0064;

    // synchroniser lanes and their idle levels
    localparam int          SYNC_W         = 7;
    localparam logic [6:0]  SYNC_RST       = 7'h17;
    localparam int          LN_CS          = 0;
    localparam int          LN_OE          = 1;
    localparam int          LN_WE          = 2;
    localparam int          LN_DIN         = 3;
    localparam int          LN_RSTPIN      = 4;
    localparam int          LN_PWRLOW      = 5;
    localparam int          LN_XTAL        = 6;

    // register map, byte addresses
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_TIME_LO    = 4'h8;
    localparam logic [3:0]  REG_TIME_HI    = 4'hc;
    localparam logic        CTRL_RST       = 1'b0;

    typedef enum logic [1:0] {
        PHRTC_DEAD  = 2'b00,
        PHRTC_ARMED = 2'b01,
        PHRTC_OPEN  = 2'b11
    } phrtc_mode_t;
endpackage

/* File: rtl/phrtc_sync3.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module phrtc_sync3 #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } phrtc_sync_t;

    phrtc_sync_t stage_r;
    phrtc_sync_t stage_nxt;

    // s1 feeds only s2; a lane changes once s2 and s3 agree
    always_comb begin
        stage_nxt    = stage_r;
        stage_nxt.s1 = d;
        stage_nxt.s2 = stage_r.s1;
        stage_nxt.s3 = stage_r.s2;
        for (int i = 0; i < W; i++) begin
            if (stage_r.s2[i] == stage_r.s3[i]) begin
                stage_nxt.q[i] = stage_r.s3[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            stage_r <= stage_nxt;
        end
    end

    assign q = stage_r.q;
endmodule

/* File: rtl/phrtc_calendar.sv */
// bcd clock/calendar counters with byte-wide load
`timescale 1ns/10ps
module phrtc_calendar
    import phrtc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        tick,
    input  wire logic        load_en,
    input  wire logic [2:0]  load_idx,
    input  wire logic [7:0]  load_byte,
    output logic      [63:0] time_q
);
    typedef struct packed {
        logic [7:0] yr;
        logic [7:0] mo;
        logic [7:0] dt;
        logic [7:0] dy;
        logic [7:0] hr;
        logic [7:0] mi;
        logic [7:0] se;
        logic [7:0] hu;
    } phrtc_cal_t;

    phrtc_cal_t cal_r;
    phrtc_cal_t cal_nxt;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // every year divisible by four counts as leap
    function automatic logic [7:0] last_day(input logic [7:0] mo,
                                            input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                        || yr[3:0] == 4'h8);
        unique case (mo)
            8'h02:                      last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default:                    last_day = 8'h31;
        endcase
    endfunction

    always_comb begin
        logic [63:0] v;
        logic        dayc;
        logic [7:0]  hinc;
        v       = cal_r;
        dayc    = 1'b0;
        hinc    = 8'h00;
        cal_nxt = cal_r;
        if (load_en) begin
            // zero bits stay zero whatever is written
            v[{load_idx, 3'b000} +: 8] = load_byte
                                         & TIME_MASK[{load_idx, 3'b000} +: 8];
            cal_nxt = v;
        end else if (tick && !cal_r.dy[5]) begin
            cal_nxt.hu = (cal_r.hu == 8'h99) ? 8'h00 : bcd_inc(cal_r.hu);
            if (cal_r.hu == 8'h99) begin
                cal_nxt.se = (cal_r.se == 8'h59) ? 8'h00 : bcd_inc(cal_r.se);
            end
            if (cal_r.hu == 8'h99 && cal_r.se == 8'h59) begin
                cal_nxt.mi = (cal_r.mi == 8'h59) ? 8'h00 : bcd_inc(cal_r.mi);
            end
            if (cal_r.hu == 8'h99 && cal_r.se == 8'h59
                && cal_r.mi == 8'h59) begin
                if (cal_r.hr[7]) begin
                    if (cal_r.hr[4:0] == 5'h12) begin
                        cal_nxt.hr[4:0] = 5'h01;
                    end else if (cal_r.hr[4:0] == 5'h11) begin
                        cal_nxt.hr[4:0] = 5'h12;
                        cal_nxt.hr[5]   = ~cal_r.hr[5];
                        dayc            = cal_r.hr[5];
                    end else begin
                        hinc            = bcd_inc({3'b000, cal_r.hr[4:0]});
                        cal_nxt.hr[4:0] = hinc[4:0];
                    end
                end else if (cal_r.hr[5:0] == 6'h23) begin
                    cal_nxt.hr[5:0] = 6'h00;
                    dayc            = 1'b1;
                end else begin
                    hinc            = bcd_inc({2'b00, cal_r.hr[5:0]});
                    cal_nxt.hr[5:0] = hinc[5:0];
                end
            end
            if (dayc) begin
                cal_nxt.dy[2:0] = (cal_r.dy[2:0] == 3'h7) ? 3'h1
                                  : cal_r.dy[2:0] + 3'h1;
                // month end follows month length and leap year
                if (cal_r.dt == last_day(cal_r.mo, cal_r.yr)) begin
                    cal_nxt.dt = 8'h01;
                    cal_nxt.mo = (cal_r.mo == 8'h12) ? 8'h01
                                 : bcd_inc(cal_r.mo);
                    if (cal_r.mo == 8'h12) begin
                        cal_nxt.yr = (cal_r.yr == 8'h99) ? 8'h00
                                     : bcd_inc(cal_r.yr);
                    end
                end else begin
                    cal_nxt.dt = bcd_inc(cal_r.dt);
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_r <= TIME_RST;
        end else begin
            cal_r <= cal_nxt;
        end
    end

    assign time_q = cal_r;
endmodule

/* File: testbench/phrtc_top_chk_sva.sv */
// pin-level assertions for the phantom clock top
`timescale 1ns/10ps
module phrtc_top_chk (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        chip_select_in_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic        power_fail_threshold,
    input  wire logic        data_out,
    input  wire logic        data_out_oe,
    input  wire logic        gated_memory_select_n
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_CS_GATES: assert property (
        chip_select_in_n |-> gated_memory_select_n)
        else $error("memory selected with chip select high");
    AST_PFAIL_GATES: assert property (
        power_fail_threshold |-> gated_memory_select_n)
        else $error("memory selected during power fail");
    AST_OPEN_BLOCKS_MEM: assert property (
        data_out_oe |-> gated_memory_select_n)
        else $error("memory selected while clock drives data");
    AST_READ_DECODE: assert property (
        $rose(data_out_oe) |-> !$past(output_enable_n, 2)
        && $past(write_enable_n, 2) && !$past(chip_select_in_n, 2))
        else $error("data driven without a read cycle");
    AST_DESEL_RELEASES: assert property (
        $rose(chip_select_in_n) && data_out_oe |-> ##[1:6] !data_out_oe)
        else $error("data still driven after deselect");
    AST_DOUT_HOLDS: assert property (
        data_out_oe && $past(data_out_oe) |-> $stable(data_out))
        else $error("read bit changed while driven");
    AST_PFAIL_REFUSES: assert property (
        power_fail_threshold [*8] |-> !data_out_oe)
        else $error("clock answered during power fail");
    AST_MODE_CODE: assert property (
        hsel && htrans[1] && hready && !hwrite && haddr[3:0] == 4'h4
        |=> hrdata[17:16] != 2'b10)
        else $error("illegal access mode code");

    cover property ($rose(data_out_oe));
    cover property (power_fail_threshold && !chip_select_in_n);
    cover property (!chip_select_in_n && !write_enable_n
        && gated_memory_select_n);
endmodule

bind phrtc_top phrtc_top_chk i_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hrdata, .chip_select_in_n,
    .output_enable_n, .write_enable_n, .power_fail_threshold, .data_out,
    .data_out_oe, .gated_memory_select_n);

/* File: testbench/phrtc_host_model.sv */
// host memory bus and crystal model driving the clock's pins
`timescale 1ns/10ps
module phrtc_host_model (
    input  wire logic hclk,
    output logic      cs_n,
    output logic      oe_n,
    output logic      we_n,
    output logic      din,
    output logic      xtal,
    input  wire logic dout,
    input  wire logic dout_oe,
    input  wire logic gated_n
);
    // bytes c5 3a a3 5c twice, sent lsb first
    localparam logic [63:0] HOST_KEY = 64'h5ca3_3ac5_5ca3_3ac5;
    logic [8:0] xcnt;

    initial begin
        cs_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        din  = 1'b0;
        xtal = 1'b0;
        xcnt = 9'h000;
    end

    // roughly 32.768 khz from the bus clock, close enough for counting
    always @(posedge hclk) begin
        if (xcnt == 9'h17c) begin
            xcnt <= 9'h000;
            xtal <= ~xtal;
        end else begin
            xcnt <= xcnt + 9'h001;
        end
    end

    // pulses of 7 edges and gaps of 9 stay well above the sync limit
    task automatic cycle(input logic wr, input logic b,
                         output logic [2:0] q);
        @(posedge hclk);
        cs_n <= 1'b0;
        oe_n <= wr;
        we_n <= ~wr;
        din  <= b;
        repeat (6) @(posedge hclk);
        q = {gated_n, dout_oe, dout};
        @(posedge hclk);
        cs_n <= 1'b1;
        oe_n <= 1'b1;
        we_n <= 1'b1;
        din  <= ~b;
        repeat (8) @(posedge hclk);
    endtask

    // strobes toggle while the clock is not selected
    task automatic desel();
        @(posedge hclk);
        we_n <= 1'b0;
        oe_n <= 1'b0;
        din  <= ~din;
        repeat (6) @(posedge hclk);
        we_n <= 1'b1;
        oe_n <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask

    task automatic unlock();
        logic [2:0] q;
        cycle(1'b0, 1'b0, q);
        for (int k = 0; k < 64; k++) begin
            if (k == 32)
                desel();
            cycle(1'b1, HOST_KEY[k], q);
        end
    endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the phantom clock top level
`timescale 1ns/10ps
module testbench
    import phrtc_pkg::*;
;
    localparam logic [63:0] TVAL = 64'h2412_1503_0823_4512;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        reset_pin_n = 1'b1;
    logic        power_fail_threshold = 1'b0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        cs_n;
    logic        oe_n;
    logic        we_n;
    logic        din;
    logic        xtal;
    logic        data_out;
    logic        data_out_oe;
    logic        gated_n;
    logic        xo;
    int          bad_count = 0;
    int          n_tests = 0;

    always #20 hclk = ~hclk;

    phrtc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .chip_select_in_n(cs_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .data_in(din), .data_out, .data_out_oe,
        .gated_memory_select_n(gated_n), .reset_pin_n,
        .power_fail_threshold, .crystal_in(xtal), .crystal_out(xo));
    phrtc_host_model i_host (.hclk, .cs_n, .oe_n, .we_n, .din, .xtal,
        .dout(data_out), .dout_oe(data_out_oe), .gated_n);

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 16);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t: bus wait ran out", $time);
            final_report();
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check(64'(hresp), 64'h0);
    endtask

    task automatic check_time(input logic [63:0] exp);
        logic [31:0] lo;
        logic [31:0] hi;
        xfer(1'b0, 32'h0000_0008, 32'h0, lo);
        xfer(1'b0, 32'h0000_000c, 32'h0, hi);
        check({hi, lo}, exp);
    endtask

    task automatic check_stat(input logic [1:0] mode, input logic [5:0] p);
        logic [31:0] sw;
        xfer(1'b0, 32'h0000_0004, 32'h0, sw);
        check(64'({sw[17:16], sw[5:0]}), 64'({mode, p}));
    endtask

    // crystal output must be the inverse of the crystal once settled
    task automatic t_xtal();
        logic x0;
        int   i;
        for (int s = 0; s < 2; s++) begin
            x0 = xtal;
            i  = 0;
            while (xtal === x0 && i < 800) begin
                @(posedge hclk);
                i++;
            end
            if (xtal === x0) begin
                bad_count++;
                $display("[ERR] %0t: crystal never toggled", $time);
                final_report();
            end
            repeat (8) @(posedge hclk);
            check(64'(xo ^ xtal), 64'h1);
        end
        $display("test crystal done");
    endtask

    task automatic t_bus();
        logic [31:0] d;
        logic [2:0]  q;
        xfer(1'b0, 32'h0000_0000, 32'h0, d);
        check(64'(d), 64'h0);
        check_stat(2'h0, 6'h00);
        // read-only place: the write must leave time untouched
        xfer(1'b1, 32'h0000_0008, 32'hffff_ffff, d);
        check_time(TIME_RST);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0001, d);
        xfer(1'b0, 32'h0000_0000, 32'h0, d);
        check(64'(d), 64'h1);
        i_host.cycle(1'b0, 1'b0, q);
        check(64'(q[2]), 64'h1);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0000, d);
        i_host.cycle(1'b0, 1'b0, q);
        check(64'(q[2]), 64'h0);
        $display("test bus done");
    endtask

    task automatic t_open();
        logic [2:0] q;
        i_host.unlock();
        check_stat(2'h3, 6'h00);
        for (int i = 0; i < 64; i++) begin
            i_host.cycle(1'b0, 1'b0, q);
            check(64'(q), 64'({2'h3, TIME_RST[i]}));
        end
        check_stat(2'h0, 6'h00);
        i_host.cycle(1'b0, 1'b0, q);
        check(64'(q[2:1]), 64'h0);
        $display("test open done");
    endtask

    task automatic t_miss();
        logic [2:0] q;
        i_host.cycle(1'b0, 1'b0, q);
        // third bit sent wrong: pointer stops at two, fourth is ignored
        for (int k = 0; k < 4; k++)
            i_host.cycle(1'b1, i_host.HOST_KEY[k] ^ (k == 2), q);
        check_stat(2'h0, 6'h02);
        i_host.cycle(1'b0, 1'b0, q);
        for (int k = 0; k < 3; k++)
            i_host.cycle(1'b1, i_host.HOST_KEY[k], q);
        check_stat(2'h1, 6'h03);
        i_host.cycle(1'b0, 1'b0, q);
        check_stat(2'h1, 6'h00);
        $display("test mismatch done");
    endtask

    task automatic t_write();
        logic [2:0] q;
        i_host.unlock();
        for (int i = 0; i < 64; i++) begin
            i_host.cycle(1'b1, TVAL[i], q);
            check(64'(q[2:1]), 64'h2);
        end
        check_time(TVAL);
        $display("test write done");
    endtask

    task automatic t_abort();
        logic [2:0] q;
        for (int s = 0; s < 2; s++) begin
            i_host.unlock();
            for (int i = 0; i < 4; i++)
                i_host.cycle(1'b1, ~TVAL[i], q);
            @(posedge hclk);
            power_fail_threshold <= (s == 0);
            reset_pin_n <= (s == 0);
            repeat (10) @(posedge hclk);
            i_host.cycle(1'b0, 1'b0, q);
            // power fail gates the memory, the reset pin does not
            check(64'(q[2:1]), 64'({s == 0, 1'b0}));
            @(posedge hclk);
            power_fail_threshold <= 1'b0;
            reset_pin_n <= 1'b1;
            repeat (8) @(posedge hclk);
            check_stat(2'h0, 6'h00);
            check_time(TVAL);
        end
        $display("test abort done");
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_bus();
        t_xtal();
        t_open();
        t_miss();
        t_write();
        t_abort();
        final_report();
    end
endmodule
